// [design/hwr_pkg.sv]
// Purpose: Shared constants and types for the halt, wake-up and reset sequencer.
// Assumes: APB register map with one aligned 32-bit word per register.
// Notes:   Only the 1024-cycle start-up count comes from the device; the map is local.
package hwr_pkg;

	// Start-up delay in system clock pulses
	localparam int unsigned STARTUP_CYCLES = 1024;
	localparam int          CNT_W          = 11;
	localparam int          IRQ_N          = 3;
	localparam int          PORTA_W        = 8;

	// APB register byte offsets
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_STATUS   = 8'h04;
	localparam logic [7:0] OFS_WAKEMASK = 8'h08;

	// Control register layout and reset value
	localparam int         CTRL_WDT_OSC_BIT = 0;
	localparam int         CTRL_WDT_EN_BIT  = 1;
	localparam logic [1:0] CTRL_RESET       = 2'h3;

	// Status register layout
	localparam int STS_PD_BIT    = 0;
	localparam int STS_TO_BIT    = 1;
	localparam int STS_STATE_LSB = 2;
	localparam int STS_CAUSE_LSB = 4;
	localparam int STS_RUN_BIT   = 7;

	// Sequencer states, Gray coded along reset, run, halt, wake
	typedef enum logic [1:0] {
		HWR_ST_RESET = 2'h0,
		HWR_ST_RUN   = 2'h1,
		HWR_ST_HALT  = 2'h3,
		HWR_ST_WAKE  = 2'h2
	} hwr_state_t;

	// Last reset or wake-up cause
	typedef enum logic [2:0] {
		HWR_CS_POWER = 3'h0,
		HWR_CS_EXT   = 3'h1,
		HWR_CS_WDT   = 3'h2,
		HWR_CS_IRQ   = 3'h3,
		HWR_CS_PORT  = 3'h4
	} hwr_cause_t;

	// Reset-cause flag pair as seen in the status register
	typedef struct packed {
		logic timeout_flag;
		logic powerdown_flag;
	} hwr_flags_t;

	localparam hwr_flags_t FLAGS_POWERUP = 2'h0;
	localparam hwr_flags_t FLAGS_EXT_HLT = 2'h1;
	localparam hwr_flags_t FLAGS_WDT_HLT = 2'h3;

endpackage

// [design/hwr_halt_ctrl.sv]
// Purpose: Halt entry, wake-up and reset sequencing with reset-cause flags.
// Assumes: All inputs synchronous to core_clk; core reports instructions as pulses.
// Notes:   core_clk models the always-on part; sys_osc_en_ff gates the real oscillator.
// What this block does
// [RULE1] Halt stops system oscillator, watchdog oscillator runs
// [RULE2] Halt keeps memory and registers unchanged
// [RULE3] Halt clears watchdog when on own oscillator
// [RULE4] Ports hold direction and level in halt
// [RULE5] Halt sets powerdown flag, clears timeout flag
// [RULE6] Exit on reset, interrupt, port edge, watchdog
// [RULE7] External reset full init; watchdog halt warm
// [RULE8] Powerdown flag: power-up/clear-watchdog clear, halt sets
// [RULE9] Each port A bit wake-up by mask
// [RULE10] Port wake-up resumes at next instruction
// [RULE11] Disabled or stack-full interrupt resumes next instruction
// [RULE12] Already pending interrupt cannot wake
// [RULE13] Wait 1024 clocks after every wake-up
// [RULE14] Interrupt serviced after delay; resume immediate
// [RULE15] Flag pair encodes the reset cause
// [RULE16] Start-up timer extends resets by 1024 clocks
// [RULE17] Chip reset initialises core, watchdog, ports
// [RULE18] Warm reset zeroes PC, sets both flags
// [RULE19] Running watchdog timeout: chip reset, timeout set
// [RULE20] Software idles pins before halt
// [RULE21] Instruction-clocked watchdog stops in halt
// [RULE22] Delay counter runs on restarted clock only
`timescale 1ns/1ns
module hwr_halt_ctrl
	import hwr_pkg::*;
#(
	parameter logic [PORTA_W-1:0] WAKE_MASK = 8'hFF,
	parameter int unsigned        STARTUP   = STARTUP_CYCLES
) (
	input  wire logic               core_clk,
	input  wire logic               rst,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [7:0]         paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire logic               external_reset_pin_n,
	input  wire logic               halt_exec,
	input  wire logic               clear_watchdog_instruction,
	input  wire logic               watchdog_overflow,
	input  wire logic [IRQ_N-1:0]   irq_req,
	input  wire logic [IRQ_N-1:0]   irq_src_en,
	input  wire logic               irq_master_en,
	input  wire logic               stack_full,
	input  wire logic [PORTA_W-1:0] porta_in,
	output logic                    sys_osc_en_ff,
	output logic                    core_run_ff,
	output logic                    chip_reset_ff,
	output logic                    warm_reset_ff,
	output logic                    watchdog_clear_ff,
	output logic                    wdt_run_ff,
	output logic                    irq_take_ff,
	output logic                    halt_hold_ff,
	output hwr_flags_t              status_flags_ff
);

	localparam logic [CNT_W-1:0] DLY_LOAD = CNT_W'(STARTUP - 1);
	localparam logic [CNT_W-1:0] DLY_DONE = '0;

	hwr_state_t         state_ff;
	hwr_state_t         nxt_state;
	hwr_cause_t         cause_ff;
	hwr_cause_t         nxt_cause;
	hwr_flags_t         nxt_flags;
	logic [CNT_W-1:0]   dly_cnt_ff;
	logic [IRQ_N-1:0]   irq_pre_ff;
	logic [IRQ_N-1:0]   irq_woke_ff;
	logic [PORTA_W-1:0] porta_prev_ff;
	logic [1:0]         ctrl_ff;
	logic               load_cnt;
	logic               do_full;
	logic               do_warm;
	logic               do_wdt_clr;
	logic               do_take;
	logic               ext_low;
	logic               wdt_hit;
	logic               osc_sel;
	logic [IRQ_N-1:0]   irq_wake;
	logic [PORTA_W-1:0] porta_fall;
	logic [2:0]         rd_hit;
	logic               apb_done;

	// One-hot register decode shared by the read and write paths
	function automatic logic [2:0] reg_decode(input logic [7:0] addr);
		reg_decode = {addr == OFS_WAKEMASK, addr == OFS_STATUS, addr == OFS_CTRL};
	endfunction

	// Wake sources; a request pending at halt entry is masked out
	assign ext_low    = ~external_reset_pin_n;
	assign osc_sel    = ctrl_ff[CTRL_WDT_OSC_BIT];
	assign wdt_hit    = watchdog_overflow & ctrl_ff[CTRL_WDT_EN_BIT];
	assign irq_wake   = irq_req & ~irq_pre_ff; // RULE12
	assign porta_fall = porta_prev_ff & ~porta_in & WAKE_MASK; // RULE9
	assign rd_hit     = reg_decode(paddr);
	assign apb_done   = psel & penable & pready;

	// Sequencer decisions; reset pin beats watchdog beats interrupt beats port
	always_comb begin
		nxt_state  = state_ff;
		nxt_cause  = cause_ff;
		nxt_flags  = status_flags_ff;
		load_cnt   = 1'b0;
		do_full    = 1'b0;
		do_warm    = 1'b0;
		do_wdt_clr = 1'b0;
		do_take    = 1'b0;
		unique case (state_ff)
			HWR_ST_RESET: begin
				if (ext_low) begin
					load_cnt = 1'b1; // RULE16
				end else if (dly_cnt_ff == DLY_DONE) begin
					nxt_state = HWR_ST_RUN;
				end
			end
			HWR_ST_RUN: begin
				if (ext_low) begin
					nxt_state = HWR_ST_RESET; // RULE15
					nxt_cause = HWR_CS_EXT;
					load_cnt  = 1'b1;
					do_full   = 1'b1;
				end else if (wdt_hit) begin
					nxt_state              = HWR_ST_RESET; // RULE19
					nxt_cause              = HWR_CS_WDT;
					nxt_flags.timeout_flag = 1'b1;
					load_cnt               = 1'b1;
					do_full                = 1'b1;
				end else if (halt_exec) begin
					nxt_state  = HWR_ST_HALT;
					nxt_flags  = FLAGS_EXT_HLT; // RULE5 RULE8
					do_wdt_clr = osc_sel; // RULE3
				end else if (clear_watchdog_instruction) begin
					nxt_flags.powerdown_flag = 1'b0; // RULE8
					do_wdt_clr               = 1'b1;
				end
			end
			HWR_ST_HALT: begin
				if (ext_low) begin
					nxt_state = HWR_ST_RESET; // RULE6 RULE7
					nxt_cause = HWR_CS_EXT;
					nxt_flags = FLAGS_EXT_HLT; // RULE15
					load_cnt  = 1'b1;
					do_full   = 1'b1;
				end else if (wdt_hit && osc_sel) begin
					nxt_state = HWR_ST_WAKE; // RULE7 RULE21
					nxt_cause = HWR_CS_WDT;
					nxt_flags = FLAGS_WDT_HLT; // RULE18
					load_cnt  = 1'b1;
					do_warm   = 1'b1;
				end else if (|irq_wake) begin
					nxt_state = HWR_ST_WAKE; // RULE6
					nxt_cause = HWR_CS_IRQ;
					load_cnt  = 1'b1;
				end else if (|porta_fall) begin
					nxt_state = HWR_ST_WAKE; // RULE6
					nxt_cause = HWR_CS_PORT;
					load_cnt  = 1'b1;
				end
			end
			HWR_ST_WAKE: begin
				if (ext_low) begin
					nxt_state = HWR_ST_RESET;
					nxt_cause = HWR_CS_EXT;
					load_cnt  = 1'b1;
					do_full   = 1'b1;
				end else if (dly_cnt_ff == DLY_DONE) begin
					nxt_state = HWR_ST_RUN; // RULE10 RULE13
					// Vector only when enabled and the stack has room
					do_take = (cause_ff == HWR_CS_IRQ) && irq_master_en && // RULE11
					          (|(irq_woke_ff & irq_src_en)) && !stack_full;
				end
			end
		endcase
	end

	// State, cause and flags; power-up reads as flags 0,0
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_ff        <= HWR_ST_RESET;
			cause_ff        <= HWR_CS_POWER;
			status_flags_ff <= FLAGS_POWERUP; // RULE15
		end else begin
			state_ff        <= nxt_state;
			cause_ff        <= nxt_cause;
			status_flags_ff <= nxt_flags;
		end
	end

	// Dummy-period counter; frozen while the oscillator is stopped
	always_ff @(posedge core_clk) begin
		if (rst) begin
			dly_cnt_ff <= DLY_LOAD;
		end else if (load_cnt) begin
			dly_cnt_ff <= DLY_LOAD; // RULE13 RULE16
		end else if (sys_osc_en_ff && dly_cnt_ff != DLY_DONE) begin
			dly_cnt_ff <= dly_cnt_ff - 1'b1; // RULE22
		end
	end

	// Snapshot of pending requests at halt entry and of the waking ones
	always_ff @(posedge core_clk) begin
		if (rst) begin
			irq_pre_ff  <= '0;
			irq_woke_ff <= '0;
		end else begin
			if (state_ff == HWR_ST_RUN && nxt_state == HWR_ST_HALT) begin
				irq_pre_ff <= irq_req; // RULE12
			end
			if (state_ff == HWR_ST_HALT && nxt_cause == HWR_CS_IRQ) begin
				irq_woke_ff <= irq_wake;
			end
		end
	end

	// Port A history for falling-edge detection
	always_ff @(posedge core_clk) begin
		if (rst) begin
			porta_prev_ff <= '0;
		end else begin
			porta_prev_ff <= porta_in;
		end
	end

	// Control outputs, all registered from the next state, the sequencer decisions and the control bits
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sys_osc_en_ff     <= 1'b1;
			core_run_ff       <= 1'b0;
			chip_reset_ff     <= 1'b1;
			warm_reset_ff     <= 1'b0;
			watchdog_clear_ff <= 1'b1;
			wdt_run_ff        <= 1'b0;
			irq_take_ff       <= 1'b0;
			halt_hold_ff      <= 1'b0;
		end else begin
			sys_osc_en_ff     <= nxt_state != HWR_ST_HALT; // RULE1
			core_run_ff       <= nxt_state == HWR_ST_RUN; // RULE14
			chip_reset_ff     <= nxt_state == HWR_ST_RESET; // RULE17
			warm_reset_ff     <= do_warm; // RULE18
			// Reset keeps the watchdog cleared; it counts once released
			watchdog_clear_ff <= do_wdt_clr | (nxt_state == HWR_ST_RESET); // RULE3 RULE17
			wdt_run_ff        <= ctrl_ff[CTRL_WDT_EN_BIT] &&
			                     !(nxt_state == HWR_ST_HALT && !osc_sel); // RULE21
			irq_take_ff       <= do_take; // RULE14
			// Core freezes its registers, RAM and port drivers on this
			halt_hold_ff      <= nxt_state == HWR_ST_HALT; // RULE2 RULE4
		end
	end

	// APB ready: one wait state keeps read data a straight register
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pready <= 1'b0;
		end else begin
			pready <= psel & penable & ~pready;
		end
	end

	// APB read data and error for unmapped addresses
	always_ff @(posedge core_clk) begin
		if (rst) begin
			prdata  <= '0;
			pslverr <= 1'b0;
		end else if (psel && penable && !pready) begin
			pslverr <= ~|rd_hit;
			prdata  <= '0;
			if (!pwrite && rd_hit[0]) begin
				prdata <= 32'(ctrl_ff);
			end
			if (!pwrite && rd_hit[1]) begin
				prdata <= 32'({core_run_ff, cause_ff, state_ff, status_flags_ff});
			end
			if (!pwrite && rd_hit[2]) begin
				prdata <= 32'(WAKE_MASK);
			end
		end else begin
			pslverr <= 1'b0;
		end
	end

	// Control register write; watchdog source and enable
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ctrl_ff <= CTRL_RESET;
		end else if (apb_done && pwrite && rd_hit[0]) begin
			ctrl_ff <= pwdata[1:0];
		end
	end

	// Checks on the sequencer
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence halt_cmd_s;
		state_ff == HWR_ST_RUN && halt_exec && external_reset_pin_n && !wdt_hit;
	endsequence

	sequence halt_wake_s;
		state_ff == HWR_ST_HALT && external_reset_pin_n && !(wdt_hit && osc_sel) &&
		!(|irq_wake) && (|porta_fall);
	endsequence

	halt_flags_a: assert property (halt_cmd_s |=> state_ff == HWR_ST_HALT && // RULE5
		status_flags_ff == FLAGS_EXT_HLT && !sys_osc_en_ff && halt_hold_ff)
		else $error("halt entry flags or clock wrong");

	halt_wdclr_a: assert property (halt_cmd_s and osc_sel |=> watchdog_clear_ff) // RULE3
		else $error("watchdog not cleared on halt");

	osc_off_a: assert property (state_ff == HWR_ST_HALT |-> !sys_osc_en_ff && !core_run_ff) // RULE1
		else $error("oscillator running in halt");

	port_wake_a: assert property (halt_wake_s |=> state_ff == HWR_ST_WAKE && // RULE6
		cause_ff == HWR_CS_PORT && dly_cnt_ff == DLY_LOAD ##1 !core_run_ff)
		else $error("port wake-up not taken");

	pend_irq_a: assert property (state_ff == HWR_ST_HALT && external_reset_pin_n && // RULE12
		!wdt_hit && (irq_req & ~irq_pre_ff) == '0 && porta_fall == '0 |=> state_ff == HWR_ST_HALT)
		else $error("woke without a fresh source");

	wake_end_a: assert property (state_ff == HWR_ST_WAKE && dly_cnt_ff == DLY_DONE && // RULE13
		external_reset_pin_n |=> core_run_ff && state_ff == HWR_ST_RUN)
		else $error("no resume at end of dummy period");

	cnt_step_a: assert property (state_ff == HWR_ST_WAKE && dly_cnt_ff != DLY_DONE && // RULE22
		external_reset_pin_n |=> dly_cnt_ff == $past(dly_cnt_ff) - 1'b1)
		else $error("delay counter not stepping");

	warm_rst_a: assert property (state_ff == HWR_ST_HALT && external_reset_pin_n && // RULE18
		wdt_hit && osc_sel |=> warm_reset_ff && !chip_reset_ff && status_flags_ff == FLAGS_WDT_HLT)
		else $error("warm reset wrong");

	run_wdt_a: assert property (state_ff == HWR_ST_RUN && external_reset_pin_n && wdt_hit |=> // RULE19
		chip_reset_ff && status_flags_ff.timeout_flag ##1 chip_reset_ff)
		else $error("watchdog timeout reset wrong");

	wdt_stop_a: assert property (state_ff == HWR_ST_HALT && !osc_sel |-> !wdt_run_ff) // RULE21
		else $error("instruction-clocked watchdog ran in halt");

	irq_take_a: assert property (irq_take_ff |-> core_run_ff && // RULE11
		$past(state_ff) == HWR_ST_WAKE && $past(cause_ff) == HWR_CS_IRQ && !$past(stack_full))
		else $error("interrupt vectoring without cause");

	clr_pd_a: assert property (state_ff == HWR_ST_RUN && clear_watchdog_instruction && // RULE8
		!halt_exec && external_reset_pin_n && !wdt_hit |=> !status_flags_ff.powerdown_flag)
		else $error("powerdown flag not cleared");

	// Reset-cause flags and the full reset taken from the reset pin
	ext_halt_a: assert property (state_ff == HWR_ST_HALT && ext_low |=> chip_reset_ff && // RULE15
		state_ff == HWR_ST_RESET && status_flags_ff == FLAGS_EXT_HLT)
		else $error("reset pin in halt gave wrong flags");

	ext_run_a: assert property (state_ff == HWR_ST_RUN && ext_low |=> chip_reset_ff && // RULE15
		status_flags_ff == $past(status_flags_ff))
		else $error("reset pin in run changed the flags");

	irq_wake_a: assert property (state_ff == HWR_ST_HALT && external_reset_pin_n && // RULE6
		!(wdt_hit && osc_sel) && (|irq_wake) |=> state_ff == HWR_ST_WAKE && cause_ff == HWR_CS_IRQ)
		else $error("interrupt wake-up not taken");

	rst_init_a: assert property (state_ff == HWR_ST_RESET |-> chip_reset_ff && // RULE17
		watchdog_clear_ff && !core_run_ff && sys_osc_en_ff)
		else $error("reset outputs wrong");

	osc_on_a: assert property (state_ff == HWR_ST_WAKE |-> sys_osc_en_ff && // RULE22
		!halt_hold_ff && !core_run_ff)
		else $error("dummy period without running clock");

endmodule

// [verification/hwr_core_model.sv]
// Purpose: Core-side stand-in that issues halt and clear-watchdog pulses.
// Assumes: A core issues instructions only while it is allowed to run.
// Notes:   Port pins and interrupt flags are driven by the bench itself.
`timescale 1ns/1ns
module hwr_core_model
	import hwr_pkg::*;
(
	input  wire logic core_clk,
	input  wire logic core_run_ff,
	input  wire logic do_halt,
	input  wire logic do_clr,
	output logic      halt_exec,
	output logic      clear_watchdog_instruction
);
	// One-cycle pulses; a frozen core cannot issue, so requests then are dropped
	always_ff @(posedge core_clk) begin
		halt_exec <= do_halt & core_run_ff;
		clear_watchdog_instruction <= do_clr & core_run_ff;
	end
endmodule

// [verification/tb_top.sv]
// Purpose: Self-checking bench for the halt, wake-up and reset sequencer.
// Assumes: Short start-up count so each wake-up costs few cycles.
// Notes:   Pulse outputs are counted at each edge, then compared as deltas.
`timescale 1ns/1ns
module tb_top;
	import hwr_pkg::*;
	localparam int unsigned SU = 8;
	logic               core_clk = 1'b0;
	logic               rst = 1'b1;
	logic               psel = 1'b0;
	logic               penable = 1'b0;
	logic               pwrite = 1'b0;
	logic [7:0]         paddr = 8'h00;
	logic [31:0]        pwdata = 32'h0;
	logic [31:0]        prdata;
	logic [31:0]        rd;
	logic               pready;
	logic               pslverr;
	logic               err;
	logic               ext_n = 1'b1;
	logic               wdo = 1'b0;
	logic [IRQ_N-1:0]   irq_req = 3'h0;
	logic [IRQ_N-1:0]   irq_en = 3'h7;
	logic               irq_mst = 1'b1;
	logic               stack_full = 1'b0;
	logic [PORTA_W-1:0] porta = 8'hFF;
	logic               do_halt = 1'b0;
	logic               do_clr = 1'b0;
	logic               halt_exec;
	logic               clr_wd;
	logic               osc_en;
	logic               run;
	logic               chip_rst;
	logic               warm;
	logic               wclr;
	logic               wdt_run;
	logic               take;
	logic               hold;
	hwr_flags_t         flags;
	int                 miscompares = 0;
	int                 check_count = 0;
	int                 n;
	int                 n_warm = 0;
	int                 n_take = 0;
	int                 n_wclr = 0;
	int                 t0;

	hwr_halt_ctrl #(.STARTUP(SU)) u_dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.external_reset_pin_n(ext_n), .halt_exec(halt_exec), .clear_watchdog_instruction(clr_wd),
		.watchdog_overflow(wdo), .irq_req(irq_req), .irq_src_en(irq_en), .irq_master_en(irq_mst),
		.stack_full(stack_full), .porta_in(porta), .sys_osc_en_ff(osc_en), .core_run_ff(run),
		.chip_reset_ff(chip_rst), .warm_reset_ff(warm), .watchdog_clear_ff(wclr), .wdt_run_ff(wdt_run),
		.irq_take_ff(take), .halt_hold_ff(hold), .status_flags_ff(flags));
	hwr_core_model u_core (.core_clk(core_clk), .core_run_ff(run), .do_halt(do_halt), .do_clr(do_clr),
		.halt_exec(halt_exec), .clear_watchdog_instruction(clr_wd));

	// 125 MHz core clock
	initial begin
		forever #4 core_clk = ~core_clk;
	end

	// Pulse counters; a one-cycle pulse is easy to miss by direct sampling
	always @(posedge core_clk) begin
		if (warm === 1'b1) n_warm <= n_warm + 1;
		if (take === 1'b1) n_take <= n_take + 1;
		if (wclr === 1'b1) n_wclr <= n_wclr + 1;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish;
		$display("checks=%0d mismatches=%0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// APB transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		i = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (pready !== 1'b1) begin
			miscompares++;
			tally_and_finish;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	function automatic logic sig(input int s);
		case (s)
			0: return run;
			1: return hold;
			2: return osc_en;
			default: return chip_rst;
		endcase
	endfunction

	// Bounded wait; k is the number of edges taken
	task automatic waitfor(input int s, input logic v, output int k);
		k = 0;
		do begin
			@(posedge core_clk);
			#1;
			k++;
		end while (sig(s) !== v && k < 3000);
		if (sig(s) !== v) begin
			miscompares++;
			tally_and_finish;
		end
	endtask

	task automatic halt;
		int k;
		@(posedge core_clk);
		do_halt <= 1'b1;
		@(posedge core_clk);
		do_halt <= 1'b0;
		waitfor(1, 1'b1, k);
	endtask

	task automatic pulse_wdo;
		@(posedge core_clk);
		wdo <= 1'b1;
		@(posedge core_clk);
		wdo <= 1'b0;
	endtask

	initial begin
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		#1 chk(chip_rst, 1'b1);
		waitfor(0, 1'b1, n);
		chk(n, SU);
		chk(flags, FLAGS_POWERUP);
		chk(chip_rst, 1'b0);
		apb(1'b0, OFS_CTRL, 32'h0);
		chk(rd, CTRL_RESET);
		apb(1'b0, OFS_WAKEMASK, 32'h0);
		chk(rd, 32'hFF);
		apb(1'b0, 8'h0C, 32'h0);
		chk(err, 1'b1);
		apb(1'b1, OFS_STATUS, 32'hFFFFFFFF);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(rd[1:0], FLAGS_POWERUP);
		chk(rd[STS_RUN_BIT], 1'b1);
		// Halt, then wake on a port A falling edge
		t0 = n_wclr;
		halt;
		repeat (3) @(posedge core_clk);
		chk(flags, FLAGS_EXT_HLT);
		chk(osc_en, 1'b0);
		chk(hold, 1'b1);
		chk(wdt_run, 1'b1);
		chk(run, 1'b0);
		chk(n_wclr - t0, 1);
		porta <= 8'hFE;
		waitfor(2, 1'b1, n);
		t0 = n_take;
		waitfor(0, 1'b1, n);
		chk(n, SU);
		@(posedge core_clk);
		#1 chk(n_take - t0, 0);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(rd[6:4], HWR_CS_PORT);
		porta <= 8'hFF;
		@(posedge core_clk);
		do_clr <= 1'b1;
		@(posedge core_clk);
		do_clr <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1 chk(flags, FLAGS_POWERUP);
		// Pending request at entry cannot wake; a fresh one can
		irq_req <= 3'h1;
		halt;
		repeat (20) @(posedge core_clk);
		#1 chk(hold, 1'b1);
		irq_req <= 3'h3;
		t0 = n_take;
		waitfor(0, 1'b1, n);
		@(posedge core_clk);
		#1 chk(n_take - t0, 1);
		irq_req <= 3'h0;
		irq_mst <= 1'b0;
		halt;
		irq_req <= 3'h4;
		t0 = n_take;
		waitfor(0, 1'b1, n);
		@(posedge core_clk);
		#1 chk(n_take - t0, 0);
		irq_req <= 3'h0;
		irq_mst <= 1'b1;
		// Watchdog overflow in halt gives a warm reset
		halt;
		t0 = n_warm;
		pulse_wdo;
		waitfor(0, 1'b1, n);
		chk(n_warm - t0, 1);
		chk(flags, FLAGS_WDT_HLT);
		// Instruction-clocked watchdog cannot wake
		apb(1'b1, OFS_CTRL, 32'h2);
		halt;
		pulse_wdo;
		repeat (10) @(posedge core_clk);
		#1 chk(hold, 1'b1);
		chk(wdt_run, 1'b0);
		ext_n <= 1'b0;
		waitfor(3, 1'b1, n);
		chk(flags, FLAGS_EXT_HLT);
		ext_n <= 1'b1;
		waitfor(0, 1'b1, n);
		apb(1'b1, OFS_CTRL, 32'h3);
		// Watchdog overflow while running
		pulse_wdo;
		waitfor(3, 1'b1, n);
		chk(flags, FLAGS_WDT_HLT);
		waitfor(0, 1'b1, n);
		ext_n <= 1'b0;
		waitfor(3, 1'b1, n);
		chk(flags, FLAGS_WDT_HLT);
		ext_n <= 1'b1;
		waitfor(0, 1'b1, n);
		tally_and_finish;
	end
endmodule
